// [hw/pbc_basic_control.sv]
`timescale 1ns/10ps
// What this block does
// - control register at management address zero, reset value 0x1000 except strapped bits.
// - writing one to bit 15 resets the device; bit clears when reset finishes.
// - bit 14 enables loopback when one; resets to zero.
// - speed code msb,lsb: 01 is 100 Mbps, 00 is 10 Mbps, others reserved.
// - speed lsb, autonegotiation enable and power-down defaults come from strap pins.
// - bit 12 enables autonegotiation when one; nominal reset value one.
// - bit 11 set powers the device down; clearing restores normal operation.
// - isolate bit one tristates all MAC interface pins.
// - writing one to bit 9 restarts autonegotiation; bit clears after restart.
// - collision test bit one enables collision signal test; resets to zero.
// - one-way transmit bit reads zero; transmit enabled only with valid link.
module pbc_basic_control
  import pbc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // management register access
  input wire logic [PBC_ADDR_W-1:0] i_mgmt_addr,
  input wire logic i_mgmt_wr,
  input wire logic i_mgmt_rd,
  input wire logic [PBC_DATA_W-1:0] i_mgmt_wdata,
  output logic [PBC_DATA_W-1:0] o_mgmt_rdata,
  // strap pins
  input wire logic i_strap_speed_lsb,
  input wire logic i_strap_aneg_enable,
  input wire logic i_strap_power_down,
  // link state
  input wire logic i_link_up,
  // controls to the transceiver
  output logic o_phy_reset,
  output logic o_loopback,
  output logic [1:0] o_speed_sel,
  output logic o_aneg_enable,
  output logic o_power_down,
  output logic o_mac_pins_oe_n,
  output logic o_aneg_restart,
  output logic o_full_duplex,
  output logic o_col_test,
  output logic o_mac_tx_enable
);
  logic [2:0] strap_s1_r;
  logic [2:0] strap_s2_r;
  logic [1:0] strap_cnt_r;
  logic strap_load;
  logic loopback_r;
  logic speed_lsb_r;
  logic speed_msb_r;
  logic aneg_en_r;
  logic power_down_r;
  logic isolate_r;
  logic duplex_r;
  logic col_test_r;
  logic ctrl_wr;
  logic rst_busy;
  logic rst_done;
  logic rst_start;
  logic rs_busy;
  logic rs_done;
  logic rs_start;
  logic [PBC_DATA_W-1:0] ctrl_value;
  logic [PBC_DATA_W-1:0] rdata_r;
  logic tx_en_r;

  function automatic logic hit_ctrl(input logic [PBC_ADDR_W-1:0] addr);
    hit_ctrl = (addr == PBC_ADDR_CTRL);
  endfunction : hit_ctrl

  // strap pins pass two flops, then load once the pipe is filled
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_s1_r <= 3'h0;
      strap_s2_r <= 3'h0;
    end else begin
      strap_s1_r <= {i_strap_power_down, i_strap_aneg_enable, i_strap_speed_lsb};
      strap_s2_r <= strap_s1_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_cnt_r <= 2'h0;
    end else if (strap_cnt_r != PBC_STRAP_SYNC_DONE + 2'h1) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
    end
  end

  // load once, in the cycle the second flop first holds the pin value
  assign strap_load = (strap_cnt_r == PBC_STRAP_SYNC_DONE);

  // writes are refused while the soft reset runs
  assign ctrl_wr = i_mgmt_wr && hit_ctrl(i_mgmt_addr) && !rst_busy;
  assign rst_start = ctrl_wr && i_mgmt_wdata[PBC_B_SOFT_RESET];
  assign rs_start = ctrl_wr && i_mgmt_wdata[PBC_B_RESTART];

  pbc_self_clear #(
    .CYCLES(PBC_SOFT_RESET_CYCLES)
  ) u_soft_reset (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_start(rst_start),
    .o_busy(rst_busy),
    .o_done(rst_done)
  );

  pbc_self_clear #(
    .CYCLES(PBC_RESTART_CYCLES)
  ) u_restart (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_start(rs_start),
    .o_busy(rs_busy),
    .o_done(rs_done)
  );

  // plain fields: reset value, soft reset end, software write
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      loopback_r <= PBC_CTRL_RESET[PBC_B_LOOPBACK];
      speed_msb_r <= PBC_CTRL_RESET[PBC_B_SPEED_MSB];
      isolate_r <= PBC_CTRL_RESET[PBC_B_ISOLATE];
      duplex_r <= PBC_CTRL_RESET[PBC_B_DUPLEX];
      col_test_r <= PBC_CTRL_RESET[PBC_B_COL_TEST];
    end else if (rst_done) begin
      loopback_r <= PBC_CTRL_RESET[PBC_B_LOOPBACK];
      speed_msb_r <= PBC_CTRL_RESET[PBC_B_SPEED_MSB];
      isolate_r <= PBC_CTRL_RESET[PBC_B_ISOLATE];
      duplex_r <= PBC_CTRL_RESET[PBC_B_DUPLEX];
      col_test_r <= PBC_CTRL_RESET[PBC_B_COL_TEST];
    end else if (ctrl_wr) begin
      loopback_r <= i_mgmt_wdata[PBC_B_LOOPBACK];
      speed_msb_r <= i_mgmt_wdata[PBC_B_SPEED_MSB];
      isolate_r <= i_mgmt_wdata[PBC_B_ISOLATE];
      duplex_r <= i_mgmt_wdata[PBC_B_DUPLEX];
      col_test_r <= i_mgmt_wdata[PBC_B_COL_TEST];
    end
  end

  // strapped fields; a software write wins over the one-time strap load
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      speed_lsb_r <= PBC_CTRL_RESET[PBC_B_SPEED_LSB];
      aneg_en_r <= PBC_CTRL_RESET[PBC_B_ANEG_EN];
      power_down_r <= PBC_CTRL_RESET[PBC_B_POWER_DOWN];
    end else if (ctrl_wr) begin
      speed_lsb_r <= i_mgmt_wdata[PBC_B_SPEED_LSB];
      aneg_en_r <= i_mgmt_wdata[PBC_B_ANEG_EN];
      power_down_r <= i_mgmt_wdata[PBC_B_POWER_DOWN];
    end else if (strap_load || rst_done) begin
      speed_lsb_r <= strap_s2_r[0];
      aneg_en_r <= strap_s2_r[1];
      power_down_r <= strap_s2_r[2];
    end
  end

  // register image; one-way bit and low field read as zero
  always_comb begin
    ctrl_value = PBC_ZERO;
    ctrl_value[PBC_B_SOFT_RESET] = rst_busy;
    ctrl_value[PBC_B_LOOPBACK] = loopback_r;
    ctrl_value[PBC_B_SPEED_LSB] = speed_lsb_r;
    ctrl_value[PBC_B_ANEG_EN] = aneg_en_r;
    ctrl_value[PBC_B_POWER_DOWN] = power_down_r;
    ctrl_value[PBC_B_ISOLATE] = isolate_r;
    ctrl_value[PBC_B_RESTART] = rs_busy;
    ctrl_value[PBC_B_DUPLEX] = duplex_r;
    ctrl_value[PBC_B_COL_TEST] = col_test_r;
    ctrl_value[PBC_B_SPEED_MSB] = speed_msb_r;
  end

  // read data registered; other addresses read zero
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_r <= PBC_ZERO;
    end else if (i_mgmt_rd) begin
      rdata_r <= hit_ctrl(i_mgmt_addr) ? ctrl_value : PBC_ZERO;
    end
  end

  // transmit only with a valid link and an active, connected device
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_en_r <= 1'b0;
    end else begin
      tx_en_r <= i_link_up && !isolate_r && !power_down_r && !rst_busy;
    end
  end

  assign o_mgmt_rdata = rdata_r;
  assign o_phy_reset = rst_busy;
  assign o_loopback = loopback_r;
  assign o_speed_sel = {speed_msb_r, speed_lsb_r};
  assign o_aneg_enable = aneg_en_r;
  assign o_power_down = power_down_r;
  assign o_mac_pins_oe_n = isolate_r;
  assign o_aneg_restart = rs_done;
  assign o_full_duplex = duplex_r;
  assign o_col_test = col_test_r;
  assign o_mac_tx_enable = tx_en_r;
endmodule : pbc_basic_control

// [hw/pbc_pkg.sv]
package pbc_pkg;
  // management register map
  localparam logic [4:0] PBC_ADDR_CTRL = 5'h00;
  localparam int PBC_ADDR_W = 5;
  localparam int PBC_DATA_W = 16;
  localparam logic [15:0] PBC_CTRL_RESET = 16'h1000;
  localparam logic [15:0] PBC_ZERO = 16'h0000;

  // field positions
  localparam int PBC_B_SOFT_RESET = 15;
  localparam int PBC_B_LOOPBACK = 14;
  localparam int PBC_B_SPEED_LSB = 13;
  localparam int PBC_B_ANEG_EN = 12;
  localparam int PBC_B_POWER_DOWN = 11;
  localparam int PBC_B_ISOLATE = 10;
  localparam int PBC_B_RESTART = 9;
  localparam int PBC_B_DUPLEX = 8;
  localparam int PBC_B_COL_TEST = 7;
  localparam int PBC_B_SPEED_MSB = 6;
  localparam int PBC_B_ONE_WAY = 5;

  // speed codes
  localparam logic [1:0] PBC_SPEED_10 = 2'h0;
  localparam logic [1:0] PBC_SPEED_100 = 2'h1;

  // timing
  localparam int PBC_CLK_PERIOD_PS = 25000;
  localparam int PBC_SOFT_RESET_TIME_NS = 1000;
  localparam int PBC_SOFT_RESET_CYCLES =
    (PBC_SOFT_RESET_TIME_NS * 1000 + PBC_CLK_PERIOD_PS - 1) / PBC_CLK_PERIOD_PS;
  localparam int PBC_RESTART_CYCLES = 1;
  localparam int PBC_CNT_W = 16;
  localparam logic [1:0] PBC_STRAP_SYNC_DONE = 2'h2;
endpackage : pbc_pkg

// [hw/pbc_self_clear.sv]
`timescale 1ns/10ps
module pbc_self_clear
  import pbc_pkg::*;
#(
  parameter int unsigned CYCLES = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // control
  input wire logic i_start,
  // status
  output logic o_busy,
  output logic o_done
);
  logic busy_r;
  logic [PBC_CNT_W-1:0] cnt_r;

  // busy holds for CYCLES cycles, a new start reloads the count
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
    end else if (i_start) begin
      busy_r <= 1'b1;
      cnt_r <= PBC_CNT_W'(CYCLES - 1);
    end else if (busy_r) begin
      if (cnt_r == '0) begin
        busy_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  assign o_busy = busy_r;
  assign o_done = busy_r && (cnt_r == '0) && !i_start;
endmodule : pbc_self_clear

// [verification/pbc_basic_control_bench.sv]
`timescale 1ns/10ps
module pbc_basic_control_bench;
  import pbc_pkg::*;
  logic i_clk, i_arst_n, i_mgmt_wr, i_mgmt_rd, i_link_up;
  logic i_strap_speed_lsb, i_strap_aneg_enable, i_strap_power_down;
  logic [4:0] i_mgmt_addr;
  logic [15:0] i_mgmt_wdata, o_mgmt_rdata, d, q;
  logic o_phy_reset, o_loopback, o_aneg_enable, o_power_down, o_mac_pins_oe_n;
  logic o_aneg_restart, o_full_duplex, o_col_test, o_mac_tx_enable;
  logic [1:0] o_speed_sel;
  int n_errors, num_checks, cyc, i;
  pbc_basic_control pbc_basic_control_i (.*);
  pbc_host pbc_host_i (.i_clk(i_clk), .o_addr(i_mgmt_addr), .o_wr(i_mgmt_wr),
    .o_rd(i_mgmt_rd), .o_wdata(i_mgmt_wdata), .i_rdata(o_mgmt_rdata));
  function logic [15:0] dflt();
    return {2'b00, i_strap_speed_lsb, i_strap_aneg_enable, i_strap_power_down, 11'h000};
  endfunction : dflt
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task stop_test();
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    q = $urandom(32'hc9ac_1d76);
    i_arst_n = 1'b0;
    i_link_up = 1'b0;
    {i_strap_speed_lsb, i_strap_aneg_enable, i_strap_power_down} = 3'($urandom);
    repeat (4) @(posedge i_clk);
    #1 i_arst_n = 1'b1;
    repeat (4) @(posedge i_clk);
    pbc_host_i.get(PBC_ADDR_CTRL, q);
    chk(q, dflt());
    for (i = 0; i < 16; i++) begin
      d = $urandom & 16'h7fff;
      d[6] = i[1];
      d[13] = i[0];
      i_link_up = 1'($urandom);
      pbc_host_i.put(PBC_ADDR_CTRL, d);
      #1;
      chk(o_aneg_restart, d[9]);
      chk(o_speed_sel, {d[6], d[13]});
      chk(o_mac_pins_oe_n, d[10]);
      chk({o_loopback, o_aneg_enable, o_power_down}, {d[14], d[12:11]});
      chk({o_full_duplex, o_col_test}, d[8:7]);
      pbc_host_i.put(5'(i + 1), ~d);
      pbc_host_i.get(PBC_ADDR_CTRL, q);
      chk(q, d & 16'h7dc0);
      chk(o_mac_tx_enable, i_link_up & !d[10] & !d[11]);
      pbc_host_i.get(5'(i + 1), q);
      chk(q, 16'h0000);
    end
    pbc_host_i.put(PBC_ADDR_CTRL, 16'h0000);
    chk(o_power_down, 1'b0);
    {i_strap_speed_lsb, i_strap_aneg_enable, i_strap_power_down} = 3'($urandom);
    pbc_host_i.put(PBC_ADDR_CTRL, 16'hc100);
    chk(o_phy_reset, 1'b1);
    pbc_host_i.put(PBC_ADDR_CTRL, 16'h0080);
    chk(o_col_test, 1'b0);
    i = 0;
    while (o_phy_reset !== 1'b0 && i < 100) begin
      @(posedge i_clk);
      #1 i++;
    end
    chk(16'(i), 16'(PBC_SOFT_RESET_CYCLES - 2));
    pbc_host_i.get(PBC_ADDR_CTRL, q);
    chk(q, dflt());
    stop_test();
  end
endmodule : pbc_basic_control_bench
bind pbc_basic_control pbc_monitor pbc_monitor_i (.*);

// [verification/pbc_host.sv]
`timescale 1ns/10ps
module pbc_host
  import pbc_pkg::*;
(
  // clock
  input wire logic i_clk,
  // management requests
  output logic [PBC_ADDR_W-1:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [PBC_DATA_W-1:0] o_wdata,
  // read answer
  input wire logic [PBC_DATA_W-1:0] i_rdata
);
  initial begin
    o_addr = 5'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 16'h0000;
  end
  // one-cycle strobe; released data shows the inverse of the last value
  task put(input logic [PBC_ADDR_W-1:0] a, input logic [PBC_DATA_W-1:0] d);
    @(posedge i_clk);
    #1 o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk);
    #1 o_wr = 1'b0;
    o_wdata = ~d;
  endtask : put
  task get(input logic [PBC_ADDR_W-1:0] a, output logic [PBC_DATA_W-1:0] d);
    @(posedge i_clk);
    #1 o_addr = a;
    o_rd = 1'b1;
    @(posedge i_clk);
    #1 o_rd = 1'b0;
    d = i_rdata;
  endtask : get
endmodule : pbc_host

// [verification/pbc_monitor.sv]
`timescale 1ns/10ps
module pbc_monitor
  import pbc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // management and link
  input wire logic [PBC_ADDR_W-1:0] i_mgmt_addr,
  input wire logic i_mgmt_wr,
  input wire logic i_mgmt_rd,
  input wire logic [PBC_DATA_W-1:0] i_mgmt_wdata,
  input wire logic [PBC_DATA_W-1:0] o_mgmt_rdata,
  input wire logic i_link_up,
  // controls
  input wire logic o_phy_reset,
  input wire logic o_loopback,
  input wire logic [1:0] o_speed_sel,
  input wire logic o_aneg_enable,
  input wire logic o_power_down,
  input wire logic o_mac_pins_oe_n,
  input wire logic o_aneg_restart,
  input wire logic o_full_duplex,
  input wire logic o_col_test,
  input wire logic o_mac_tx_enable
);
  logic wr_ok;
  logic rs;
  logic wr_q;
  logic tx_q;
  logic [15:0] wd_q;
  assign wr_ok = i_mgmt_wr && (i_mgmt_addr == PBC_ADDR_CTRL) && !o_phy_reset;
  assign rs = wr_ok && i_mgmt_wdata[PBC_B_RESTART];
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_q <= 1'b0;
      tx_q <= 1'b0;
      wd_q <= 16'h0000;
    end else begin
      wr_q <= wr_ok;
      tx_q <= i_link_up && !o_mac_pins_oe_n && !o_power_down && !o_phy_reset;
      wd_q <= i_mgmt_wdata;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_restart_pulse: assert property (rs |=> o_aneg_restart ##1 (!o_aneg_restart || $past(rs)))
    else $error("restart pulse wrong");
  a_reset_length: assert property (wr_ok && i_mgmt_wdata[15] |=> o_phy_reset[*8] ##33 !o_phy_reset)
    else $error("soft reset length wrong");
  a_reset_defaults: assert property ($fell(o_phy_reset) |-> !o_loopback && !o_full_duplex && !o_col_test && !o_mac_pins_oe_n)
    else $error("fields not restored");
  a_loopback_write: assert property (wr_q |-> o_loopback == wd_q[14])
    else $error("loopback not stored");
  a_speed_write: assert property (wr_q |-> o_speed_sel == {wd_q[6], wd_q[13]})
    else $error("speed not stored");
  a_control_write: assert property (wr_q |-> {o_aneg_enable, o_power_down, o_mac_pins_oe_n, o_full_duplex, o_col_test} == {wd_q[12:10], wd_q[8:7]})
    else $error("control bits not stored");
  a_low_zero: assert property (i_mgmt_rd |=> o_mgmt_rdata[5:0] == 6'h00)
    else $error("low field not zero");
  a_tx_gate: assert property (o_mac_tx_enable == tx_q)
    else $error("transmit enable wrong");
  c_restart: cover property (rs);
  c_reset_end: cover property ($fell(o_phy_reset));
  c_tx_on: cover property (o_mac_tx_enable);
endmodule : pbc_monitor
